// ---- design/mac_mission_alarm_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module mac_mission_alarm_control
  import mac_pkg::*;
#(
  parameter int LOG_BYTES = LOG_SIZE_BYTES
) (
  // Clock and battery-on reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWdata,
  output var  logic [7:0]  regRdata,
  // Commands, one-cycle pulses
  input  wire mac_cmd_s    cmd,
  // Thresholds
  input  wire logic [7:0]  lowThreshold,
  input  wire logic [7:0]  highThreshold,
  // Conversion results
  input  wire mac_conv_s   conv,
  // Sample timing control
  output logic             oscillatorRun,
  output logic             secondsUnitSelect,
  output logic             conversionEnable,
  output logic             conversionWide,
  // Log memory write and mission bookkeeping
  output var  mac_logwr_s  logWrite,
  output var  logic [23:0] missionSampleCount,
  output var  logic        timestampCapture,
  output var  logic        timestampClear,
  // Search response
  output logic             alarmSearchHit
);

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [1:0] {
    LOG_IDLE   = 2'b01,
    LOG_SECOND = 2'b10
  } mac_log_e;

  localparam logic [15:0] LOG_LAST = 16'(LOG_BASE_ADDR + LOG_BYTES - 1);

  logic [1:0]  alarmEnable;
  logic [1:0]  clockControl;
  logic [5:0]  missionSetup;
  logic        batteryResetFlag;
  logic        highAlarmFlag;
  logic        lowAlarmFlag;
  logic        waitingForAlarmFlag;
  logic        memoryClearedFlag;
  logic        missionActiveFlag;
  logic        memoryFull;
  logic        firstLogged;
  logic [15:0] logPointer;
  logic [7:0]  pendingLow;
  mac_log_e    logState;

  logic        highAlarmEnable;
  logic        lowAlarmEnable;
  logic        alarmStartSelect;
  logic        logWrapEnable;
  logic        sampleWidthSelect;
  logic        loggingEnable;
  logic        cfgWrite;
  logic        startOk;
  logic [7:0]  resultHigh;
  logic        checkSample;
  logic        highHit;
  logic        lowHit;
  logic        alarmHit;
  logic        missionSample;
  logic        logSample;
  logic        writeByte;
  logic        lastByte;

  // ************************************************************
  // Field decode
  // ************************************************************
  assign highAlarmEnable   = alarmEnable[HIGH_ALARM_ENABLE_BIT];
  assign lowAlarmEnable    = alarmEnable[LOW_ALARM_ENABLE_BIT];
  assign oscillatorRun     = clockControl[OSCILLATOR_RUN_BIT];
  assign secondsUnitSelect = clockControl[SECONDS_UNIT_SELECT_BIT];
  assign alarmStartSelect  = missionSetup[ALARM_START_SELECT_BIT];
  assign logWrapEnable     = missionSetup[LOG_WRAP_ENABLE_BIT];
  assign sampleWidthSelect = missionSetup[SAMPLE_WIDTH_SELECT_BIT];
  assign loggingEnable     = missionSetup[LOGGING_ENABLE_BIT];

  assign cfgWrite = regWrite && !missionActiveFlag;
  assign startOk  = cmd.startMission && memoryClearedFlag && !missionActiveFlag;

  // ************************************************************
  // Alarm compare
  // ************************************************************
  assign resultHigh    = conv.result[15:8];
  assign missionSample = conv.valid && !conv.forced && missionActiveFlag && !memoryFull;
  assign checkSample   = missionSample || (conv.valid && conv.forced);
  assign highHit = checkSample && highAlarmEnable && (resultHigh >= highThreshold);
  assign lowHit  = checkSample && lowAlarmEnable && (resultHigh <= lowThreshold);
  assign alarmHit = highHit || lowHit;

  // Waiting samples are only logged once they alarm
  assign logSample = missionSample && loggingEnable
                     && (!waitingForAlarmFlag || alarmHit)
                     && (logState == LOG_IDLE);

  // ************************************************************
  // Sample timing and search outputs
  // ************************************************************
  assign conversionEnable = missionActiveFlag && !memoryFull;
  assign conversionWide   = sampleWidthSelect && !waitingForAlarmFlag;
  assign alarmSearchHit   = batteryResetFlag || highAlarmFlag || lowAlarmFlag;

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmEnable <= ALARM_ENABLE_RESET;
    end else if (cfgWrite && regAddr == ALARM_ENABLE_CONTROL_ADDR) begin
      alarmEnable <= regWdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clockControl <= CLOCK_CONTROL_RESET;
    end else begin
      if (cfgWrite && regAddr == SAMPLE_CLOCK_CONTROL_ADDR) begin
        clockControl <= regWdata[1:0];
      end
      if (cmd.forcedConversion || startOk) begin
        clockControl[OSCILLATOR_RUN_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      missionSetup <= MISSION_SETUP_RESET;
    end else if (cfgWrite && regAddr == MISSION_SETUP_ADDR) begin
      missionSetup <= regWdata[5:0];
    end
  end

  // ************************************************************
  // Alarm flags
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      batteryResetFlag <= 1'b1;
    end else if (cmd.clearMemory && !missionActiveFlag) begin
      batteryResetFlag <= 1'b0;
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highAlarmFlag <= 1'b0;
      lowAlarmFlag  <= 1'b0;
    end else begin
      if (cmd.clearMemory && !missionActiveFlag) begin
        highAlarmFlag <= 1'b0;
        lowAlarmFlag  <= 1'b0;
      end
      if (highHit) begin
        highAlarmFlag <= 1'b1;
      end
      if (lowHit) begin
        lowAlarmFlag <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Mission state flags
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitingForAlarmFlag <= 1'b0;
    end else if (alarmHit) begin
      waitingForAlarmFlag <= 1'b0;
    end else if (startOk && alarmStartSelect) begin
      waitingForAlarmFlag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memoryClearedFlag <= 1'b0;
    end else if (startOk) begin
      memoryClearedFlag <= 1'b0;
    end else if (cmd.clearMemory && !missionActiveFlag) begin
      memoryClearedFlag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      missionActiveFlag <= 1'b0;
    end else if (cmd.stopMission) begin
      missionActiveFlag <= 1'b0;
    end else if (startOk) begin
      missionActiveFlag <= 1'b1;
    end
  end

  // ************************************************************
  // Mission bookkeeping
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      missionSampleCount <= 24'h000000;
    end else if (cmd.clearMemory && !missionActiveFlag) begin
      missionSampleCount <= 24'h000000;
    end else if (logSample) begin
      missionSampleCount <= missionSampleCount + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstLogged      <= 1'b0;
      timestampCapture <= 1'b0;
      timestampClear   <= 1'b0;
    end else begin
      timestampCapture <= logSample && !firstLogged;
      timestampClear   <= cmd.clearMemory && !missionActiveFlag;
      if (startOk) begin
        firstLogged <= 1'b0;
      end else if (logSample) begin
        firstLogged <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Log memory writer
  // ************************************************************
  assign writeByte = logSample || (logState == LOG_SECOND);
  assign lastByte  = (logPointer == LOG_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      logState   <= LOG_IDLE;
      pendingLow <= 8'h00;
    end else begin
      unique case (logState)
        LOG_IDLE: begin
          if (logSample && sampleWidthSelect) begin
            logState   <= LOG_SECOND;
            pendingLow <= conv.result[7:0];
          end
        end
        LOG_SECOND: begin
          logState <= LOG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      logWrite <= '0;
    end else begin
      logWrite.strobe <= writeByte;
      logWrite.addr   <= logPointer;
      if (logState == LOG_SECOND) begin
        logWrite.data <= pendingLow;
      end else begin
        logWrite.data <= resultHigh;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      logPointer <= LOG_BASE_ADDR;
      memoryFull <= 1'b0;
    end else if (startOk) begin
      logPointer <= LOG_BASE_ADDR;
      memoryFull <= 1'b0;
    end else if (writeByte) begin
      if (lastByte) begin
        logPointer <= LOG_BASE_ADDR;
        memoryFull <= !logWrapEnable;
      end else begin
        logPointer <= logPointer + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= UNMAPPED_READ;
    end else if (regRead) begin
      unique case (regAddr)
        ALARM_ENABLE_CONTROL_ADDR: begin
          regRdata <= {6'h00, alarmEnable};
        end
        SAMPLE_CLOCK_CONTROL_ADDR: begin
          regRdata <= {6'h00, clockControl};
        end
        MISSION_SETUP_ADDR: begin
          regRdata <= {SETUP_ONES, missionSetup};
        end
        ALARM_FLAGS_ADDR: begin
          regRdata <= {batteryResetFlag, ALARM_FLAGS_ONES, 2'h0,
                       highAlarmFlag, lowAlarmFlag};
        end
        MISSION_STATE_FLAGS_ADDR: begin
          regRdata <= {SETUP_ONES, 1'b0, waitingForAlarmFlag,
                       memoryClearedFlag, 1'b0, missionActiveFlag, 1'b0};
        end
        default: begin
          regRdata <= UNMAPPED_READ;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- design/mac_pkg.sv ----
`default_nettype none
package mac_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [15:0] ALARM_ENABLE_CONTROL_ADDR = 16'h0210;
  localparam logic [15:0] SAMPLE_CLOCK_CONTROL_ADDR = 16'h0212;
  localparam logic [15:0] MISSION_SETUP_ADDR        = 16'h0213;
  localparam logic [15:0] ALARM_FLAGS_ADDR          = 16'h0214;
  localparam logic [15:0] MISSION_STATE_FLAGS_ADDR  = 16'h0215;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LOW_ALARM_ENABLE_BIT     = 0;
  localparam int HIGH_ALARM_ENABLE_BIT    = 1;
  localparam int OSCILLATOR_RUN_BIT       = 0;
  localparam int SECONDS_UNIT_SELECT_BIT  = 1;
  localparam int LOGGING_ENABLE_BIT       = 0;
  localparam int SAMPLE_WIDTH_SELECT_BIT  = 2;
  localparam int LOG_WRAP_ENABLE_BIT      = 4;
  localparam int ALARM_START_SELECT_BIT   = 5;

  // ************************************************************
  // Reset values and fixed bits
  // ************************************************************
  localparam logic [1:0] ALARM_ENABLE_RESET  = 2'h0;
  localparam logic [1:0] CLOCK_CONTROL_RESET = 2'h0;
  localparam logic [5:0] MISSION_SETUP_RESET = 6'h00;
  localparam logic [1:0] SETUP_ONES          = 2'h3;
  localparam logic [2:0] ALARM_FLAGS_ONES    = 3'h7;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // ************************************************************
  // Log memory
  // ************************************************************
  localparam logic [15:0] LOG_BASE_ADDR  = 16'h1000;
  localparam int          LOG_SIZE_BYTES = 8192;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic        clearMemory;
    logic        startMission;
    logic        stopMission;
    logic        forcedConversion;
  } mac_cmd_s;

  typedef struct packed {
    logic        valid;
    logic        forced;
    logic [15:0] result;
  } mac_conv_s;

  typedef struct packed {
    logic        strobe;
    logic [15:0] addr;
    logic [7:0]  data;
  } mac_logwr_s;

endpackage
`default_nettype wire

// ---- verification/mac_alarm_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Port checker
// ************************************************************
module mac_alarm_monitor
  import mac_pkg::*;
#(
  parameter int LOG_BYTES = LOG_SIZE_BYTES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register port
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regAddr,
  input wire logic [7:0]  regRdata,
  // Commands and conversions
  input wire mac_cmd_s    cmd,
  input wire mac_conv_s   conv,
  // Outputs watched
  input wire logic        oscillatorRun,
  input wire mac_logwr_s  logWrite,
  input wire logic [23:0] missionSampleCount,
  input wire logic        timestampClear,
  input wire logic        alarmSearchHit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_enable_zero: assert property (regRead && (regAddr == ALARM_ENABLE_CONTROL_ADDR ||
    regAddr == SAMPLE_CLOCK_CONTROL_ADDR) |=> regRdata[7:2] == 6'h00) else $error("upper bits set");
  a_setup_ones: assert property (regRead && regAddr == MISSION_SETUP_ADDR
    |=> regRdata[7:6] == 2'h3 && !regRdata[1]) else $error("setup fixed bits wrong");
  a_flags_fixed: assert property (regRead && regAddr == ALARM_FLAGS_ADDR
    |=> regRdata[6:2] == 5'h1c) else $error("alarm flags fixed bits wrong");
  a_state_fixed: assert property (regRead && regAddr == MISSION_STATE_FLAGS_ADDR
    |=> regRdata[7:5] == 3'h6 && !regRdata[2] && !regRdata[0]) else $error("state fixed bits wrong");
  a_search_match: assert property (regRead && regAddr == ALARM_FLAGS_ADDR && !conv.valid &&
    !cmd.clearMemory |=> alarmSearchHit == (regRdata[7] | regRdata[1] | regRdata[0]))
    else $error("search hit differs from flags");
  a_osc_force: assert property (cmd.forcedConversion && !regWrite |=> oscillatorRun)
    else $error("oscillator not started");
  a_stamp_clear: assert property (timestampClear |-> $past(cmd.clearMemory) &&
    missionSampleCount == 24'h0) else $error("clear pulse without clear");
  a_log_range: assert property (logWrite.strobe |-> logWrite.addr >= LOG_BASE_ADDR &&
    logWrite.addr < LOG_BASE_ADDR + LOG_BYTES) else $error("log address out of range");
  a_msb_first: assert property (logWrite.strobe && $past(conv.valid)
    |-> logWrite.data == $past(conv.result[15:8])) else $error("first byte not high byte");
  a_byte_pair: assert property (logWrite.strobe && $past(logWrite.strobe)
    |-> logWrite.addr == $past(logWrite.addr) + 16'h1) else $error("low byte misplaced");
  a_count_step: assert property (missionSampleCount != $past(missionSampleCount) |->
    missionSampleCount == 24'h0 || (missionSampleCount == $past(missionSampleCount) + 24'h1 &&
    $past(conv.valid))) else $error("sample count step wrong");

  c_clear: cover property (timestampClear);
  c_log: cover property (logWrite.strobe ##1 logWrite.strobe);
  c_hit: cover property ($rose(alarmSearchHit));
endmodule

bind mac_mission_alarm_control mac_alarm_monitor #(.LOG_BYTES(LOG_BYTES)) i_mon (
  .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regRdata(regRdata), .cmd(cmd), .conv(conv), .oscillatorRun(oscillatorRun), .logWrite(logWrite),
  .missionSampleCount(missionSampleCount), .timestampClear(timestampClear), .alarmSearchHit(alarmSearchHit));
`default_nettype wire

// ---- verification/mac_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Register bus host
// ************************************************************
module mac_host_model
  import mac_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register port
  output var  logic        regWrite,
  output var  logic        regRead,
  output var  logic [15:0] regAddr,
  output var  logic [7:0]  regWdata,
  input  wire logic [7:0]  regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 16'hffff;
    regWdata = 8'hff;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= (a == MISSION_SETUP_ADDR) ? (v & 8'hfd) : v;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~v;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 v = regRdata;
  endtask
endmodule
`default_nettype wire

// ---- verification/mission_alarm_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin badCount++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
// ************************************************************
// Bench top
// ************************************************************
module mission_alarm_control_test;
  import mac_pkg::*;
  logic        clk, rst_n, regWrite, regRead, osc, sec, convEn, convWide, tsCap, tsClr, hit, cap;
  logic [15:0] regAddr;
  logic [7:0]  regWdata, regRdata, d, lowT, highT;
  logic [23:0] cnt;
  mac_cmd_s    cmd;
  mac_conv_s   conv;
  mac_logwr_s  logWrite, w;
  int          badCount = 0;
  int          nCompared = 0;
  int          cycles = 0;

  mac_host_model i_host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  mac_mission_alarm_control #(.LOG_BYTES(8)) i_dut (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .cmd(cmd),
    .lowThreshold(lowT), .highThreshold(highT), .conv(conv), .oscillatorRun(osc),
    .secondsUnitSelect(sec), .conversionEnable(convEn), .conversionWide(convWide), .logWrite(logWrite),
    .missionSampleCount(cnt), .timestampCapture(tsCap), .timestampClear(tsClr), .alarmSearchHit(hit));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      printVerdict();
    end
  end

  task printVerdict;
    if (badCount == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic pulse(input mac_cmd_s c);
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= '0;
    #1;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    `CHK(d, e)
  endtask

  task automatic sample(input logic [15:0] r, input logic f = 1'b0);
    @(posedge clk) conv <= '{1'b1, f, r};
    @(posedge clk) conv.valid <= 1'b0;
    #1 w = logWrite;
    cap = tsCap;
    @(posedge clk);
    @(posedge clk);
    #1;
  endtask

  task t_reset;
    rchk(ALARM_FLAGS_ADDR, 8'hf0);
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hc0);
    rchk(MISSION_SETUP_ADDR, 8'hc0);
    `CHK(hit, 1'b1)
    pulse(4'b0100);
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hc0);
  endtask

  task t_regs;
    i_host.wr(ALARM_ENABLE_CONTROL_ADDR, 8'hff);
    rchk(ALARM_ENABLE_CONTROL_ADDR, 8'h03);
    i_host.wr(SAMPLE_CLOCK_CONTROL_ADDR, 8'hfe);
    rchk(SAMPLE_CLOCK_CONTROL_ADDR, 8'h02);
    `CHK({osc, sec}, 2'b01)
    pulse(4'b0001);
    `CHK(osc, 1'b1)
    i_host.wr(SAMPLE_CLOCK_CONTROL_ADDR, 8'h00);
    `CHK({osc, sec}, 2'b00)
  endtask

  task t_clear;
    pulse(4'b1000);
    `CHK(tsClr, 1'b1)
    rchk(ALARM_FLAGS_ADDR, 8'h70);
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hc8);
    `CHK(hit, 1'b0)
  endtask

  task t_mission;
    i_host.wr(MISSION_SETUP_ADDR, 8'h05);
    i_host.wr(ALARM_ENABLE_CONTROL_ADDR, 8'h03);
    pulse(4'b0100);
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hc2);
    `CHK({osc, convEn}, 2'b11)
    `CHK(convWide, 1'b1)
    i_host.wr(ALARM_ENABLE_CONTROL_ADDR, 8'h00);
    rchk(ALARM_ENABLE_CONTROL_ADDR, 8'h03);
    sample(16'h5460);
    `CHK({w, cap}, {1'b1, 16'h1000, 8'h54, 1'b1})
    rchk(ALARM_FLAGS_ADDR, 8'h72);
    `CHK(hit, 1'b1)
    sample(16'h30ff);
    sample(16'h17ff);
    rchk(ALARM_FLAGS_ADDR, 8'h73);
    sample(16'h3000);
    `CHK({cnt, convEn}, {24'h4, 1'b0})
    pulse(4'b0010);
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hc0);
  endtask

  task t_alarm_start;
    i_host.wr(MISSION_SETUP_ADDR, 8'h31);
    i_host.wr(ALARM_ENABLE_CONTROL_ADDR, 8'h02);
    pulse(4'b0100);
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hd2);
    sample(16'h5300);
    `CHK({w.strobe, cnt, cap}, {1'b0, 24'h0, 1'b0})
    sample(16'h6000);
    `CHK({w, cnt, cap}, {1'b1, 16'h1000, 8'h60, 24'h1, 1'b1})
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hc2);
    rchk(ALARM_FLAGS_ADDR, 8'h72);
    repeat (8) sample(16'h2000);
    `CHK({w.addr, cnt}, {16'h1000, 24'h9})
    pulse(4'b0010);
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hc0);
  endtask

  task t_forced;
    pulse(4'b0100);
    pulse(4'b0010);
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hd0);
    sample(16'h1000, 1'b1);
    rchk(ALARM_FLAGS_ADDR, 8'h70);
    sample(16'h6000, 1'b1);
    `CHK({w.strobe, cnt, cap}, {1'b0, 24'h0, 1'b0})
    rchk(MISSION_STATE_FLAGS_ADDR, 8'hc0);
    rchk(ALARM_FLAGS_ADDR, 8'h72);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cmd = '0;
    conv = '0;
    lowT = 8'h17;
    highT = 8'h54;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_clear();
    t_mission();
    t_clear();
    t_alarm_start();
    t_clear();
    t_forced();
    printVerdict();
  end
endmodule
`default_nettype wire
